// ---- pkg/fieldbus_ctrl_params.svh ----
// Purpose: named constants for the fieldbus control/status interpreter
// Assumes: 16-bit control, status, reference and frequency words
// Notes: bit positions of control and status words
`ifndef FIELDBUS_CTRL_PARAMS_SVH
`define FIELDBUS_CTRL_PARAMS_SVH

`define PROFILE_ALT 8'h00
// Control word bits
`define CW_ON1 0
`define CW_ON2 1
`define CW_ON3 2
`define CW_NOCOAST 3
`define CW_NOQSTOP 4
`define CW_NOFREEZE 5
`define CW_START 6
`define CW_RESET 7
`define CW_JOG1 8
`define CW_JOG2 9
`define CW_VALID 10
`define CW_SLOW 11
`define CW_CATCH 12
`define CW_SETUP_LO 13
`define CW_SETUP_HI 14
`define CW_REV 15
// Status word bits
`define SW_CTRL_RDY 0
`define SW_DRV_RDY 1
`define SW_NOCOAST 2
`define SW_TRIP 3
`define SW_OFF2 4
`define SW_OFF3 5
`define SW_START_DIS 6
`define SW_WARN 7
`define SW_AT_REF 8
`define SW_SERIAL 9
`define SW_IN_LIMIT 10
`define SW_RUNNING 11
`define SW_VOLT_WARN 13
`define SW_CURR_LIM 14
`define SW_THERM_WARN 15
// Reset values
`define WORD_ZERO 16'h0000
`define SETUP_ZERO 2'h0
// Scale: 16384 is full span
`define FULL_SCALE_SHIFT 14

`endif

// ---- pkg/fieldbus_ctrl_pkg.sv ----
// Purpose: types for the fieldbus control/status interpreter
// Assumes: nothing beyond the params header
// Notes: state structs of each module
package fieldbus_ctrl_pkg;

  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] ref_sum;
    logic reverse;
    logic [1:0] setup;
  } ref_state_t;

  typedef struct packed {
    logic [15:0] freq;
  } scale_state_t;

  typedef enum logic [1:0] {ST_DISABLED, ST_READY, ST_RUN, ST_TRIPPED} drive_mode_t;

  typedef struct packed {
    logic [15:0] cmd;
    drive_mode_t mode;
    logic start_dis;
    logic trip;
    logic [15:0] status;
    logic [15:0] freq_word;
    logic [15:0] speed_ref;
    logic reverse;
    logic [1:0] setup;
    logic run_enable;
    logic ramp_stop;
    logic coast;
    logic quick_stop;
    logic freeze;
    logic trip_reset;
    logic relay;
    logic jog1;
    logic jog2;
  } top_state_t;

endpackage : fieldbus_ctrl_pkg

// ---- logic/ref_adjust.sv ----
// Purpose: applies slow-down/catch-up offset and direction to the reference
// Assumes: inputs from logic on the same clock
// Notes: one cycle latency; result saturates at +/-32767
`timescale 1ns/1ns
`include "fieldbus_ctrl_params.svh"
module ref_adjust
  import fieldbus_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Accepted command and inputs
  input wire logic [15:0] cmd,
  input wire logic [15:0] bus_ref,
  input wire logic [15:0] trim_amount,
  input wire logic rev_from_bit,
  // Results
  output logic [15:0] adj_ref,
  output logic reverse,
  output logic [1:0] setup
);
  ref_state_t s_q, s_d;
  logic signed [17:0] sum;

  always_comb begin
    s_d = s_q;
    s_d.cmd = cmd;
    sum = 18'(signed'(bus_ref));
    if (cmd[`CW_SLOW]) begin
      sum = sum - 18'(trim_amount);
    end else if (cmd[`CW_CATCH]) begin
      sum = sum + 18'(trim_amount);
    end
    if (sum > 18'sd32767) begin
      s_d.ref_sum = 16'h7fff;
    end else if (sum < -18'sd32767) begin
      s_d.ref_sum = 16'h8001;
    end else begin
      s_d.ref_sum = sum[15:0];
    end
    // Negative reference or bit 15 (when routed) requests reversing
    s_d.reverse = sum[17] | (rev_from_bit & cmd[`CW_REV]);
    s_d.setup = {cmd[`CW_SETUP_HI], cmd[`CW_SETUP_LO]};
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign adj_ref = s_q.ref_sum;
  assign reverse = s_q.reverse;
  assign setup = s_q.setup;

  AST_SLOW_WINS: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cmd[`CW_SLOW] && cmd[`CW_CATCH] && trim_amount != 16'h0000 && signed'(bus_ref) > -16'sd32767)
      |=> signed'(adj_ref) < signed'($past(bus_ref)))
    else $error("catch-up won over slow-down");
endmodule : ref_adjust

// ---- logic/freq_scale.sv ----
// Purpose: scales output frequency to the 16384-per-span word
// Assumes: freq between limits given in Hz units of the core
// Notes: one cycle latency; span zero reports zero
`timescale 1ns/1ns
`include "fieldbus_ctrl_params.svh"
module freq_scale
  import fieldbus_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Frequency and limits
  input wire logic [15:0] out_freq,
  input wire logic [15:0] low_limit,
  input wire logic [15:0] high_limit,
  input wire logic neg_dir,
  // Scaled word
  output logic [15:0] freq_word
);
  scale_state_t s_q, s_d;
  logic [15:0] span;
  logic [31:0] num;
  logic [31:0] q;

  always_comb begin
    s_d = s_q;
    span = high_limit - low_limit;
    num = {16'h0000, out_freq - low_limit} << `FULL_SCALE_SHIFT;
    q = (span == 16'h0000) ? 32'h0000_0000 : num / {16'h0000, span};
    if (q > 32'h0000_7fff) begin
      q = 32'h0000_7fff;
    end
    s_d.freq = neg_dir ? 16'(-q[15:0]) : q[15:0];
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign freq_word = s_q.freq;
endmodule : freq_scale

// ---- logic/drive_fieldbus_control_status.sv ----
// Purpose: interprets the fieldbus control word and builds the status word
// Assumes: telegram transport decoded elsewhere; all inputs on core_clk
// Notes: accepts command words only in the alternate profile with the data-valid bit set
`timescale 1ns/1ns
`include "fieldbus_ctrl_params.svh"
module drive_fieldbus_control_status
  import fieldbus_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Telegram words from the master
  input wire logic word_strobe,
  input wire logic [15:0] command_word,
  input wire logic [15:0] bus_ref,
  // Configuration
  input wire logic [7:0] profile_sel,
  input wire logic relay_on_stop_cfg,
  input wire logic rev_from_bit,
  input wire logic [15:0] trim_amount,
  input wire logic [15:0] freq_low_limit,
  input wire logic [15:0] freq_high_limit,
  // Drive core state
  input wire logic drive_ready,
  input wire logic fault,
  input wire logic warning,
  input wire logic at_ref,
  input wire logic serial_ctrl,
  input wire logic volt_warn,
  input wire logic curr_limit,
  input wire logic therm_warn,
  input wire logic [15:0] out_freq,
  // Status to the master
  output logic [15:0] drive_state_word,
  output logic [15:0] out_freq_word,
  // Commands to the drive core
  output logic run_enable,
  output logic ramp_stop,
  output logic coast,
  output logic quick_stop,
  output logic freeze,
  output logic trip_reset,
  output logic jog1_sel,
  output logic jog2_sel,
  output logic [15:0] speed_ref,
  output logic reverse,
  output logic [1:0] setup_sel,
  output logic stop_relay
);
  top_state_t s_q, s_d;
  logic accept;
  logic off_any;
  logic [15:0] c;
  logic [15:0] sw;
  logic [15:0] adj_ref;
  logic adj_rev;
  logic [1:0] adj_setup;
  logic [15:0] fw;
  logic reset_edge;

  //----------------------------------------------------------------------
  // Decode helpers
  //----------------------------------------------------------------------
  // All three off-command bits released
  function automatic logic offs_released(input logic [15:0] w);
    return w[`CW_ON1] && w[`CW_ON2] && w[`CW_ON3];
  endfunction : offs_released

  //----------------------------------------------------------------------
  // Submodules
  //----------------------------------------------------------------------
  ref_adjust i_ref_adjust (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cmd(s_q.cmd),
    .bus_ref(bus_ref),
    .trim_amount(trim_amount),
    .rev_from_bit(rev_from_bit),
    .adj_ref(adj_ref),
    .reverse(adj_rev),
    .setup(adj_setup)
  );

  freq_scale i_freq_scale (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .out_freq(out_freq),
    .low_limit(freq_low_limit),
    .high_limit(freq_high_limit),
    .neg_dir(s_q.reverse),
    .freq_word(fw)
  );

  //----------------------------------------------------------------------
  // Command acceptance and status
  //----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Words outside this profile or without data-valid leave the last command in force
    accept = word_strobe && profile_sel == `PROFILE_ALT && command_word[`CW_VALID];
    if (accept) begin
      s_d.cmd = command_word;
    end
    c = s_q.cmd;
    off_any = !offs_released(c);
    reset_edge = accept && command_word[`CW_RESET] && !s_q.cmd[`CW_RESET];

    // Trip latches until a reset command
    if (fault) begin
      s_d.trip = 1'b1;
    end else if (reset_edge) begin
      s_d.trip = 1'b0;
    end

    // Start disable: set wins over clear
    if ((reset_edge && s_q.trip) || !c[`CW_ON2] || !c[`CW_ON3]) begin
      s_d.start_dis = 1'b1;
    end else if (!c[`CW_ON1] && c[`CW_VALID]) begin
      s_d.start_dis = 1'b0;
    end

    unique case (s_q.mode)
      ST_DISABLED: begin
        if (!s_d.start_dis && !s_q.trip) begin
          s_d.mode = ST_READY;
        end
      end
      ST_READY: begin
        if (s_q.trip) begin
          s_d.mode = ST_TRIPPED;
        end else if (!off_any && c[`CW_START] && drive_ready && c[`CW_NOCOAST]) begin
          s_d.mode = ST_RUN;
        end
      end
      ST_RUN: begin
        if (s_q.trip) begin
          s_d.mode = ST_TRIPPED;
        end else if (off_any || !c[`CW_START]) begin
          s_d.mode = ST_READY;
        end
      end
      ST_TRIPPED: begin
        if (!s_q.trip) begin
          s_d.mode = ST_DISABLED;
        end
      end
    endcase

    s_d.run_enable = s_q.mode == ST_RUN;
    s_d.ramp_stop = off_any || !c[`CW_START];
    s_d.coast = !c[`CW_NOCOAST] || !c[`CW_ON2];
    s_d.quick_stop = !c[`CW_NOQSTOP] || !c[`CW_ON3];
    s_d.freeze = !c[`CW_NOFREEZE];
    s_d.trip_reset = reset_edge;
    s_d.jog1 = c[`CW_JOG1];
    s_d.jog2 = c[`CW_JOG2] && !c[`CW_JOG1];
    s_d.relay = relay_on_stop_cfg && off_any && out_freq == `WORD_ZERO;
    s_d.speed_ref = adj_ref;
    s_d.reverse = adj_rev;
    s_d.setup = adj_setup;
    s_d.freq_word = fw;

    sw = `WORD_ZERO;
    sw[`SW_CTRL_RDY] = !off_any && drive_ready;
    sw[`SW_DRV_RDY] = drive_ready;
    sw[`SW_NOCOAST] = offs_released(c) && c[`CW_NOCOAST] && !s_q.trip;
    sw[`SW_TRIP] = s_q.trip;
    sw[`SW_OFF2] = !c[`CW_ON2];
    sw[`SW_OFF3] = !c[`CW_ON3];
    sw[`SW_START_DIS] = s_q.start_dis;
    sw[`SW_WARN] = warning;
    sw[`SW_AT_REF] = at_ref;
    sw[`SW_SERIAL] = serial_ctrl;
    sw[`SW_IN_LIMIT] = out_freq > freq_low_limit && out_freq < freq_high_limit;
    sw[`SW_RUNNING] = s_q.mode == ST_RUN || out_freq != `WORD_ZERO;
    sw[`SW_VOLT_WARN] = volt_warn;
    sw[`SW_CURR_LIM] = curr_limit;
    sw[`SW_THERM_WARN] = therm_warn;
    s_d.status = sw;
  end

  //----------------------------------------------------------------------
  // State register
  //----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      // Power-up leaves start disabled
      s_q.start_dis <= 1'b1;
      s_q.mode <= ST_DISABLED;
    end else begin
      s_q <= s_d;
    end
  end

  //----------------------------------------------------------------------
  // Outputs, straight from the state register
  //----------------------------------------------------------------------
  assign drive_state_word = s_q.status;
  assign out_freq_word = s_q.freq_word;
  assign run_enable = s_q.run_enable;
  assign ramp_stop = s_q.ramp_stop;
  assign coast = s_q.coast;
  assign quick_stop = s_q.quick_stop;
  assign freeze = s_q.freeze;
  assign trip_reset = s_q.trip_reset;
  assign jog1_sel = s_q.jog1;
  assign jog2_sel = s_q.jog2;
  assign speed_ref = s_q.speed_ref;
  assign reverse = s_q.reverse;
  assign setup_sel = s_q.setup;
  assign stop_relay = s_q.relay;

  //----------------------------------------------------------------------
  // Checks: acceptance and off commands
  //----------------------------------------------------------------------
  AST_IGNORE_INVALID: assert property (@(posedge core_clk) disable iff (!reset_n)
    (word_strobe && !command_word[`CW_VALID]) |=> $stable(s_q.cmd))
    else $error("invalid word changed command");
  AST_PROFILE_GATE: assert property (@(posedge core_clk) disable iff (!reset_n)
    (word_strobe && profile_sel != `PROFILE_ALT) |=> $stable(s_q.cmd))
    else $error("other profile changed command");
  AST_OFF2_STATUS: assert property (@(posedge core_clk) disable iff (!reset_n)
    (accept && !command_word[`CW_ON2]) |-> ##2 drive_state_word[`SW_OFF2])
    else $error("off2 status missing");
  AST_OFF3_STATUS: assert property (@(posedge core_clk) disable iff (!reset_n)
    (accept && command_word[`CW_ON3]) |-> ##2 !drive_state_word[`SW_OFF3])
    else $error("off3 status wrong");
  AST_CTRL_RDY: assert property (@(posedge core_clk) disable iff (!reset_n)
    (accept && !command_word[`CW_ON1]) |-> ##2 !drive_state_word[`SW_CTRL_RDY])
    else $error("control ready while off");
  AST_NOCOAST: assert property (@(posedge core_clk) disable iff (!reset_n)
    drive_state_word[`SW_NOCOAST] |-> !$past(s_q.trip))
    else $error("not-coasting while tripped");
  AST_STOP_RAMP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (accept && !command_word[`CW_ON1]) |-> ##2 ramp_stop ##1 !run_enable)
    else $error("no ramp stop on off");
  AST_TRIP_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
    (s_q.trip && !reset_edge) |=> s_q.trip)
    else $error("trip dropped without reset");
  AST_JOG1: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_q.cmd[`CW_JOG1] |=> jog1_sel && !jog2_sel)
    else $error("jog1 not selected");
  AST_RELAY: assert property (@(posedge core_clk) disable iff (!reset_n)
    stop_relay |-> $past(out_freq) == 16'h0000 && $past(relay_on_stop_cfg))
    else $error("relay without zero frequency");

  //----------------------------------------------------------------------
  // Checks: commands to the drive core
  //----------------------------------------------------------------------
  AST_CMD_TAKEN: assert property (@(posedge core_clk) disable iff (!reset_n)
    accept |=> s_q.cmd == $past(command_word))
    else $error("accepted word not registered");
  AST_COAST_CMD: assert property (@(posedge core_clk) disable iff (!reset_n)
    !s_q.cmd[`CW_NOCOAST] |=> coast)
    else $error("coast request not passed on");
  AST_QSTOP_CMD: assert property (@(posedge core_clk) disable iff (!reset_n)
    !s_q.cmd[`CW_NOQSTOP] |=> quick_stop)
    else $error("quick stop request not passed on");
  AST_FREEZE_CMD: assert property (@(posedge core_clk) disable iff (!reset_n)
    !s_q.cmd[`CW_NOFREEZE] |=> freeze)
    else $error("freeze request not passed on");
  AST_TRIP_RESET_PULSE: assert property (@(posedge core_clk) disable iff (!reset_n)
    trip_reset |=> !trip_reset)
    else $error("trip reset longer than one cycle");
  AST_RUN_NEEDS_ON: assert property (@(posedge core_clk) disable iff (!reset_n)
    run_enable |-> offs_released($past(s_q.cmd, 2)) && $past(s_q.cmd[`CW_START], 2))
    else $error("run without start conditions");
  AST_JOG2: assert property (@(posedge core_clk) disable iff (!reset_n)
    (s_q.cmd[`CW_JOG2] && !s_q.cmd[`CW_JOG1]) |=> jog2_sel && !jog1_sel)
    else $error("jog2 not selected");
  AST_RELAY_ON: assert property (@(posedge core_clk) disable iff (!reset_n)
    (relay_on_stop_cfg && !offs_released(s_q.cmd) && out_freq == `WORD_ZERO) |=> stop_relay)
    else $error("relay not energised at zero frequency");

  //----------------------------------------------------------------------
  // Checks: status word
  //----------------------------------------------------------------------
  AST_START_DIS_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!s_q.cmd[`CW_ON2] || !s_q.cmd[`CW_ON3] || (reset_edge && s_q.trip)) |=> s_q.start_dis)
    else $error("start disable not set");
  AST_START_DIS_CLR: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!s_q.cmd[`CW_ON1] && s_q.cmd[`CW_ON2] && s_q.cmd[`CW_ON3] && s_q.cmd[`CW_VALID] && !reset_edge)
      |=> !s_q.start_dis)
    else $error("start disable not cleared");
  AST_NOCOAST_CLR: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!s_q.cmd[`CW_ON1] || !s_q.cmd[`CW_ON3] || !s_q.cmd[`CW_NOCOAST]) |=> !drive_state_word[`SW_NOCOAST])
    else $error("not-coasting while off or coasting");
  AST_TRIP_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
    fault |=> ##1 drive_state_word[`SW_TRIP])
    else $error("fault not reported as trip");
  AST_DRV_RDY_FLAG: assert property (@(posedge core_clk) disable iff (!reset_n)
    drive_state_word[`SW_DRV_RDY] == $past(drive_ready))
    else $error("drive ready flag wrong");
  AST_WARN_FLAG: assert property (@(posedge core_clk) disable iff (!reset_n)
    drive_state_word[`SW_WARN] == $past(warning))
    else $error("warning flag wrong");
  AST_AT_REF_FLAG: assert property (@(posedge core_clk) disable iff (!reset_n)
    drive_state_word[`SW_AT_REF] == $past(at_ref))
    else $error("speed at reference flag wrong");
  AST_SERIAL_FLAG: assert property (@(posedge core_clk) disable iff (!reset_n)
    drive_state_word[`SW_SERIAL] == $past(serial_ctrl))
    else $error("serial control flag wrong");

  //----------------------------------------------------------------------
  // Checks: reference and direction
  //----------------------------------------------------------------------
  AST_NO_TRIM: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!s_q.cmd[`CW_SLOW] && !s_q.cmd[`CW_CATCH] && bus_ref != 16'h8000) |=> ##1 speed_ref == $past(bus_ref, 2))
    else $error("reference changed without trim");
  AST_SLOW_DOWN: assert property (@(posedge core_clk) disable iff (!reset_n)
    (s_q.cmd[`CW_SLOW] && trim_amount != `WORD_ZERO && signed'(bus_ref) > -16'sd32767)
      |=> ##1 signed'(speed_ref) < signed'($past(bus_ref, 2)))
    else $error("slow-down did not lower reference");
  AST_CATCH_UP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (s_q.cmd[`CW_CATCH] && !s_q.cmd[`CW_SLOW] && trim_amount != `WORD_ZERO && signed'(bus_ref) < 16'sd32767)
      |=> ##1 signed'(speed_ref) > signed'($past(bus_ref, 2)))
    else $error("catch-up did not raise reference");
  AST_REV_NEG: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!s_q.cmd[`CW_SLOW] && !s_q.cmd[`CW_CATCH] && signed'(bus_ref) < 0) |=> ##1 reverse)
    else $error("negative reference not reversing");
  AST_REV_BIT: assert property (@(posedge core_clk) disable iff (!reset_n)
    (rev_from_bit && s_q.cmd[`CW_REV]) |=> ##1 reverse)
    else $error("reversing bit ignored");
  AST_SETUP: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_sel == {$past(s_q.cmd[`CW_SETUP_HI], 2), $past(s_q.cmd[`CW_SETUP_LO], 2)})
    else $error("setup select wrong");
endmodule : drive_fieldbus_control_status

// ---- tb/bus_master_model.sv ----
// Purpose: behavioural fieldbus master that sends control words and references
// Assumes: one word per call, launched just after a rising edge
// Notes: the command word means nothing between strobes, so it shows the inverse of the last word
`timescale 1ns/1ns
module bus_master_model (
  // Clock
  input wire logic core_clk,
  // Telegram words
  output logic word_strobe,
  output logic [15:0] command_word,
  output logic [15:0] bus_ref
);
  initial begin
    word_strobe = 1'b0;
    command_word = 16'h0000;
    bus_ref = 16'h0000;
  end

  // ----------------------------------------
  // Send one control word with its reference
  // ----------------------------------------
  // The reference stays as a level; a negative value in two's complement asks for reversing
  task automatic send_word(input logic [15:0] cw, input logic [15:0] rf);
    @(posedge core_clk);
    #1;
    word_strobe = 1'b1;
    command_word = cw;
    bus_ref = rf;
    @(posedge core_clk);
    #1;
    word_strobe = 1'b0;
    command_word = ~cw;
  endtask : send_word
endmodule : bus_master_model

// ---- tb/drive_fieldbus_control_status_tb.sv ----
// Purpose: self-checking bench for the control/status interpreter
// Assumes: master model sends words; bench drives configuration and drive core state
// Notes: each word is given a settle time longer than the stated three-cycle latency
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module drive_fieldbus_control_status_tb;
  import fieldbus_ctrl_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic word_strobe;
  logic [15:0] command_word, bus_ref;
  logic [7:0] profile_sel = 8'h00;
  logic relay_on_stop_cfg = 1'b1;
  logic rev_from_bit = 1'b0;
  logic [15:0] trim_amount = 16'h0100;
  logic [15:0] freq_low_limit = 16'h0000;
  logic [15:0] freq_high_limit = 16'h0032;
  logic [15:0] out_freq = 16'h0000;
  logic drive_ready = 1'b0, fault = 1'b0, warning = 1'b0, at_ref = 1'b0;
  logic serial_ctrl = 1'b0, volt_warn = 1'b0, curr_limit = 1'b0, therm_warn = 1'b0;
  logic [15:0] drive_state_word, out_freq_word, speed_ref;
  logic run_enable, ramp_stop, coast, quick_stop, freeze, trip_reset;
  logic jog1_sel, jog2_sel, reverse, stop_relay;
  logic [1:0] setup_sel;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int trip_pulses = 0;

  bus_master_model i_bus_master_model (.core_clk, .word_strobe, .command_word, .bus_ref);

  drive_fieldbus_control_status i_drive_fieldbus_control_status (
    .core_clk, .reset_n, .word_strobe, .command_word, .bus_ref, .profile_sel,
    .relay_on_stop_cfg, .rev_from_bit, .trim_amount, .freq_low_limit, .freq_high_limit,
    .drive_ready, .fault, .warning, .at_ref, .serial_ctrl, .volt_warn, .curr_limit,
    .therm_warn, .out_freq, .drive_state_word, .out_freq_word, .run_enable, .ramp_stop,
    .coast, .quick_stop, .freeze, .trip_reset, .jog1_sel, .jog2_sel, .speed_ref,
    .reverse, .setup_sel, .stop_relay
  );

  always #20 core_clk = ~core_clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic test_done();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic settle();
    repeat (5) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic go(input logic [15:0] cw, input logic [15:0] rf);
    i_bus_master_model.send_word(cw, rf);
    settle();
  endtask : go

  // The reset pulse lasts one cycle, so it is counted as it passes
  always @(posedge core_clk) begin
    if (trip_reset === 1'b1) begin
      trip_pulses++;
    end
  end

  // A hung run is cut off well past the expected 170 or so cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      test_done();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    settle();
    `CHK("start_dis_pwr", 1'b1, drive_state_word[6])
    go(16'h0405, 16'h0000);
    `CHK("off2_flag", 1'b1, drive_state_word[4])
    `CHK("off3_flag", 1'b0, drive_state_word[5])
    `CHK("ctrl_rdy_off", 1'b0, drive_state_word[0])
    `CHK("ramp_stop", 1'b1, ramp_stop)
    `CHK("stop_relay", 1'b1, stop_relay)
    `CHK("start_dis_off2", 1'b1, drive_state_word[6])
    go(16'h0403, 16'h0000);
    `CHK("off3_flag_set", 1'b1, drive_state_word[5])
    `CHK("off2_flag_clr", 1'b0, drive_state_word[4])
    `CHK("nocoast_off3", 1'b0, drive_state_word[2])
    go(16'h0007, 16'h0000);
    `CHK("invalid_ignored", 1'b1, drive_state_word[5])
    profile_sel = 8'h01;
    go(16'h0407, 16'h0000);
    `CHK("profile_ignored", 1'b1, drive_state_word[5])
    profile_sel = 8'h00;
    go(16'h0406, 16'h0000);
    `CHK("start_dis_clr", 1'b0, drive_state_word[6])
    drive_ready = 1'b1;
    out_freq = 16'h0019;
    go(16'h047F, 16'h2000);
    `CHK("ctrl_rdy_on", 1'b1, drive_state_word[0])
    `CHK("nocoast_on", 1'b1, drive_state_word[2])
    `CHK("run_enable", 1'b1, run_enable)
    `CHK("ramp_release", 1'b0, ramp_stop)
    `CHK("ref_pos", 16'h2000, speed_ref)
    `CHK("fwd", 1'b0, reverse)
    `CHK("freq_word", 16'h2000, out_freq_word)
    `CHK("drv_flags", 3'b111, {drive_state_word[11:10], drive_state_word[1]})
    `CHK("cmd_release", 3'b000, {coast, quick_stop, freeze})
    `CHK("relay_off", 1'b0, stop_relay)
    go(16'h047F, 16'hE000);
    `CHK("ref_neg", 16'hE000, speed_ref)
    `CHK("rev_neg", 1'b1, reverse)
    `CHK("freq_neg", 16'hE000, out_freq_word)
    go(16'h0C7F, 16'h2000);
    `CHK("slow_down", 16'h1F00, speed_ref)
    go(16'h147F, 16'h2000);
    `CHK("catch_up", 16'h2100, speed_ref)
    go(16'h1C7F, 16'h2000);
    `CHK("slow_wins", 16'h1F00, speed_ref)
    go(16'h057F, 16'h2000);
    `CHK("jog1", 1'b1, jog1_sel)
    go(16'h067F, 16'h2000);
    `CHK("jog2", 1'b1, jog2_sel)
    `CHK("jog1_off", 1'b0, jog1_sel)
    for (int i = 0; i < 4; i++) begin
      go(16'h047F | (16'(i) << 13), 16'h2000);
      `CHK("setup", 2'(i), setup_sel)
    end
    rev_from_bit = 1'b1;
    go(16'hC47F, 16'h2000);
    `CHK("rev_bit", 1'b1, reverse)
    go(16'h047F, 16'h2000);
    `CHK("rev_bit_off", 1'b0, reverse)
    rev_from_bit = 1'b0;
    go(16'h0447, 16'h2000);
    `CHK("coast_cmd", 1'b0, drive_state_word[2])
    `CHK("stop_cmds", 3'b111, {coast, quick_stop, freeze})
    {warning, at_ref, serial_ctrl, volt_warn, curr_limit, therm_warn} = 6'h3f;
    settle();
    `CHK("pass_thru", 6'h3f, {drive_state_word[15:13], drive_state_word[9:7]})
    fault = 1'b1;
    settle();
    `CHK("trip_set", 1'b1, drive_state_word[3])
    fault = 1'b0;
    settle();
    `CHK("trip_hold", 1'b1, drive_state_word[3])
    go(16'h04FF, 16'h2000);
    `CHK("trip_clr", 1'b0, drive_state_word[3])
    `CHK("start_dis_trip", 1'b1, drive_state_word[6])
    `CHK("trip_reset_once", 1, trip_pulses)
    test_done();
  end
endmodule : drive_fieldbus_control_status_tb
